// ### ppvr_map.svh
// register map constants for the plateau and verification register pair
// assumes inclusion by the package and by design files of this block
`ifndef PPVR_MAP_SVH
`define PPVR_MAP_SVH
`define PPVR_ADDR_PLATEAU     4'h7
`define PPVR_ADDR_VERIFY      4'h8
`define PPVR_RST_PLATEAU      16'h003D
`define PPVR_RST_VERIFY       16'h0001
`define PPVR_PLAT_MSB         5
`define PPVR_PLAT_LSB         2
`define PPVR_VFS_MSB          3
`define PPVR_VFS_LSB          2
`define PPVR_LMI_BIT          1
`define PPVR_PAR_BIT          0
`define PPVR_RST_PLAT_SEL     4'hF
`define PPVR_RST_VFS          2'h0
`endif

// ### ppvr_pkg.sv
// types for the plateau and verification register pair
// assumes the map header sits in the same folder
`include "ppvr_map.svh"
package ppvr_pkg;
    typedef enum logic [1:0] {
        PPVR_VFS_NONE  = 2'h0,
        PPVR_VFS_RSVD  = 2'h1,
        PPVR_VFS_CLOCK = 2'h2,
        PPVR_VFS_DCHAN = 2'h3
    } ppvr_vfs_t;
endpackage

// ### ppvr_word.sv
// builds one register read word: field, last-message flag and odd parity
// assumes a purely combinational use inside the register bank
`timescale 1ns/1ps
module ppvr_word #(
    parameter int FW  = 4,
    parameter int LSB = 2
) (
    input  wire logic [FW-1:0] field,
    input  wire logic          last_msg_invalid,
    output logic      [15:0]   word
);
    logic [15:0] base;
    // reserved bits zero, parity makes the word odd
    always_comb begin
        base = 16'h0000;
        base[LSB +: FW] = field;
        base[1] = last_msg_invalid;
        word = {base[15:1], ~(^base[15:1])};
    end
endmodule

// ### ppvr_regs.sv
// plateau level and verification select registers of the primary side
// assumes a transport layer that delivers decoded, parity-checked requests
// and a mode machine that pulses mode-entry events on REF_CLK
//
// Operation
// - plateau selector writable at bits 5:2
// - bit 1 reports last message invalid
// - bit 0 gives odd word parity
// - verify selector decodes none, reserved, clock, channel
// - selection acts only entering verification mode
// - entering first mode clears verify selector
// - host selects function by register write only
`timescale 1ns/1ps
`include "ppvr_map.svh"
module ppvr_regs
    import ppvr_pkg::*;
(
    input  wire logic        REF_CLK,
    input  wire logic        RESETN,
    input  wire logic        WR_EN,
    input  wire logic        RD_EN,
    input  wire logic [3:0]  ADDR,
    input  wire logic [15:0] WDATA,
    input  wire logic        MSG_DONE,
    input  wire logic        MSG_DISCARD,
    input  wire logic        ENTER_FIRST_MODE,
    input  wire logic        ENTER_VERIFY_MODE,
    output logic      [15:0] RDATA,
    output logic             RD_HIT,
    output logic      [3:0]  PLATEAU_SEL,
    output logic             CLOCK_SUPV_START,
    output logic             DCHAN_SUPV_START
);
    logic [3:0]  plat_r;
    logic [1:0]  vfs_r;
    logic        lmi_r;
    logic [15:0] plat_word;
    logic [15:0] vfs_word;

    // last-message flag follows each finished message
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            lmi_r <= 1'b0;
        end else if (MSG_DONE) begin
            lmi_r <= MSG_DISCARD;
        end
    end

    // plateau selector storage
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            plat_r <= `PPVR_RST_PLAT_SEL;
        end else if (WR_EN && ADDR == `PPVR_ADDR_PLATEAU) begin
            plat_r <= WDATA[`PPVR_PLAT_MSB:`PPVR_PLAT_LSB];
        end
    end

    // verify selector: first-mode entry wins over a write
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            vfs_r <= `PPVR_RST_VFS;
        end else if (ENTER_FIRST_MODE) begin
            vfs_r <= `PPVR_RST_VFS;
        end else if (WR_EN && ADDR == `PPVR_ADDR_VERIFY) begin
            vfs_r <= WDATA[`PPVR_VFS_MSB:`PPVR_VFS_LSB];
        end
    end

    // start pulses only on verification-mode entry
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            CLOCK_SUPV_START <= 1'b0;
            DCHAN_SUPV_START <= 1'b0;
        end else begin
            CLOCK_SUPV_START <= ENTER_VERIFY_MODE && vfs_r == PPVR_VFS_CLOCK;
            DCHAN_SUPV_START <= ENTER_VERIFY_MODE && vfs_r == PPVR_VFS_DCHAN;
        end
    end

    // plateau level to the analog side
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            PLATEAU_SEL <= `PPVR_RST_PLAT_SEL;
        end else begin
            PLATEAU_SEL <= plat_r;
        end
    end

    ppvr_word #(.FW(4), .LSB(`PPVR_PLAT_LSB)) u_plat_word (
        .field (plat_r),
        .last_msg_invalid   (lmi_r),
        .word  (plat_word)
    );

    ppvr_word #(.FW(2), .LSB(`PPVR_VFS_LSB)) u_vfs_word (
        .field (vfs_r),
        .last_msg_invalid   (lmi_r),
        .word  (vfs_word)
    );

    // registered read answer, one cycle after the request
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            RDATA  <= 16'h0000;
            RD_HIT <= 1'b0;
        end else if (RD_EN) begin
            RD_HIT <= ADDR == `PPVR_ADDR_PLATEAU || ADDR == `PPVR_ADDR_VERIFY;
            if (ADDR == `PPVR_ADDR_PLATEAU) begin
                RDATA <= plat_word;
            end else if (ADDR == `PPVR_ADDR_VERIFY) begin
                RDATA <= vfs_word;
            end else begin
                RDATA <= 16'h0000;
            end
        end else begin
            RD_HIT <= 1'b0;
        end
    end

    // assertions
    property p_plat_write;
        @(posedge REF_CLK) disable iff (!RESETN)
        (WR_EN && ADDR == `PPVR_ADDR_PLATEAU) |=> plat_r == $past(WDATA[`PPVR_PLAT_MSB:`PPVR_PLAT_LSB]);
    endproperty
    a_plat_write: assert property (p_plat_write) else $error("plateau write lost");

    property p_plat_out;
        @(posedge REF_CLK) disable iff (!RESETN)
        1'b1 |=> PLATEAU_SEL == $past(plat_r);
    endproperty
    a_plat_out: assert property (p_plat_out) else $error("plateau level output lags wrongly");

    property p_reserved_zero;
        @(posedge REF_CLK) disable iff (!RESETN)
        $past(RD_EN) |-> (RDATA[15:6] == 10'h000) && ($past(ADDR) != `PPVR_ADDR_VERIFY || RDATA[5:4] == 2'h0);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits nonzero");

    property p_unmapped;
        @(posedge REF_CLK) disable iff (!RESETN)
        (RD_EN && ADDR != `PPVR_ADDR_PLATEAU && ADDR != `PPVR_ADDR_VERIFY) |=> !RD_HIT && RDATA == 16'h0000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read answered");

    property p_lmi;
        @(posedge REF_CLK) disable iff (!RESETN)
        (MSG_DONE ##1 !MSG_DONE ##1 (RD_EN && !MSG_DONE)) |=> RDATA[1] == $past(MSG_DISCARD, 3) || !RD_HIT;
    endproperty
    a_lmi: assert property (p_lmi) else $error("last message flag wrong");

    property p_lmi_update;
        @(posedge REF_CLK) disable iff (!RESETN)
        MSG_DONE |=> lmi_r == $past(MSG_DISCARD);
    endproperty
    a_lmi_update: assert property (p_lmi_update) else $error("last message flag not updated");

    property p_parity;
        @(posedge REF_CLK) disable iff (!RESETN)
        RD_HIT |-> ^RDATA == 1'b1;
    endproperty
    a_parity: assert property (p_parity) else $error("parity not odd");

    property p_clock_start;
        @(posedge REF_CLK) disable iff (!RESETN)
        (ENTER_VERIFY_MODE && vfs_r == 2'h2) |=> CLOCK_SUPV_START && !DCHAN_SUPV_START;
    endproperty
    a_clock_start: assert property (p_clock_start) else $error("clock supervision not started");

    property p_dchan_start;
        @(posedge REF_CLK) disable iff (!RESETN)
        (ENTER_VERIFY_MODE && vfs_r == PPVR_VFS_DCHAN) |=> DCHAN_SUPV_START && !CLOCK_SUPV_START;
    endproperty
    a_dchan_start: assert property (p_dchan_start) else $error("channel supervision not started");

    property p_none_start;
        @(posedge REF_CLK) disable iff (!RESETN)
        (ENTER_VERIFY_MODE && (vfs_r == PPVR_VFS_NONE || vfs_r == PPVR_VFS_RSVD))
            |=> !CLOCK_SUPV_START && !DCHAN_SUPV_START;
    endproperty
    a_none_start: assert property (p_none_start) else $error("start from idle selection");

    property p_no_start;
        @(posedge REF_CLK) disable iff (!RESETN)
        !ENTER_VERIFY_MODE |=> !CLOCK_SUPV_START && !DCHAN_SUPV_START;
    endproperty
    a_no_start: assert property (p_no_start) else $error("start outside mode entry");

    property p_first_clear;
        @(posedge REF_CLK) disable iff (!RESETN)
        ENTER_FIRST_MODE |=> vfs_r == 2'h0;
    endproperty
    a_first_clear: assert property (p_first_clear) else $error("selector not cleared");

    property p_vfs_write;
        @(posedge REF_CLK) disable iff (!RESETN)
        (WR_EN && ADDR == `PPVR_ADDR_VERIFY && !ENTER_FIRST_MODE) |=> vfs_r == $past(WDATA[`PPVR_VFS_MSB:`PPVR_VFS_LSB]);
    endproperty
    a_vfs_write: assert property (p_vfs_write) else $error("selector write lost");

    property p_stable;
        @(posedge REF_CLK) disable iff (!RESETN)
        !(WR_EN && ADDR == `PPVR_ADDR_PLATEAU) ##1 1'b1 |-> $stable(plat_r);
    endproperty
    a_stable: assert property (p_stable) else $error("plateau changed without write");

    c_clock: cover property (@(posedge REF_CLK) disable iff (!RESETN) CLOCK_SUPV_START);
    c_dchan: cover property (@(posedge REF_CLK) disable iff (!RESETN) DCHAN_SUPV_START);
    c_clear: cover property (@(posedge REF_CLK) disable iff (!RESETN) ENTER_FIRST_MODE && vfs_r != 2'h0);
    c_clash: cover property (@(posedge REF_CLK) disable iff (!RESETN)
        ENTER_FIRST_MODE && WR_EN && ADDR == `PPVR_ADDR_VERIFY);
endmodule

// ### ppvr_host.sv
// host model that issues decoded register requests to the register pair
// assumes its tasks are called from the REF_CLK domain of the bench
`timescale 1ns/1ps
module ppvr_host (
    input  wire logic        ref_clk,
    output logic             wr_en,
    output logic             rd_en,
    output logic      [3:0]  addr,
    output logic      [15:0] wdata,
    output logic             msg_done,
    output logic             msg_discard
);
    // idle bus at time zero
    initial begin
        {wr_en, rd_en, addr, wdata, msg_done, msg_discard} = '0;
    end
    // one write word; the host fills in odd parity, then scrambles the released bus
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        wr_en <= 1'b1;
        addr  <= a;
        wdata <= {d[15:1], ~^d[15:1]};
        @(posedge ref_clk);
        wr_en <= 1'b0;
        wdata <= ~wdata;
    endtask
    // one read request; returns just after the answer edge
    task automatic rd(input logic [3:0] a);
        @(posedge ref_clk);
        rd_en <= 1'b1;
        addr  <= a;
        @(posedge ref_clk);
        rd_en <= 1'b0;
        #1;
    endtask
    // end of one message, good or discarded
    task automatic msg(input logic bad);
        @(posedge ref_clk);
        msg_done    <= 1'b1;
        msg_discard <= bad;
        @(posedge ref_clk);
        msg_done    <= 1'b0;
        msg_discard <= ~bad;
    endtask
endmodule

// ### testbench.sv
// self-checking bench for the plateau and verification register pair
// assumes the design files and the host model compile first
`timescale 1ns/1ps
module testbench;
    logic        clk, resetn, efm, evm, wr_en, rd_en, done, disc, hit, csup, dsup;
    logic [3:0]  addr, psel;
    logic [15:0] wdata, rdata;
    int          fails = 0;
    int          checks = 0;
    ppvr_regs ppvr_regs_i (.REF_CLK(clk), .RESETN(resetn), .WR_EN(wr_en), .RD_EN(rd_en), .ADDR(addr),
        .WDATA(wdata), .MSG_DONE(done), .MSG_DISCARD(disc), .ENTER_FIRST_MODE(efm),
        .ENTER_VERIFY_MODE(evm), .RDATA(rdata), .RD_HIT(hit), .PLATEAU_SEL(psel),
        .CLOCK_SUPV_START(csup), .DCHAN_SUPV_START(dsup));
    ppvr_host ppvr_host_i (.ref_clk(clk), .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wdata(wdata),
        .msg_done(done), .msg_discard(disc));
    // free-running clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rchk(input logic [3:0] a, input logic [15:0] e, input logic h);
        ppvr_host_i.rd(a);
        chk(rdata, e);
        chk({15'h0, hit}, {15'h0, h});
    endtask
    // pulse verification-mode entry and judge both start pulses
    task automatic verify_start(input logic c, input logic d);
        chk({14'h0, csup, dsup}, 16'h0);
        @(posedge clk);
        evm <= 1'b1;
        @(posedge clk);
        evm <= 1'b0;
        #1;
        chk({14'h0, csup, dsup}, {14'h0, c, d});
        @(posedge clk);
        #1;
        chk({14'h0, csup, dsup}, 16'h0);
    endtask
    task automatic t_reset();
        rchk(4'h7, 16'h003D, 1'b1);
        rchk(4'h8, 16'h0001, 1'b1);
        chk({12'h0, psel}, 16'h000F);
        rchk(4'h3, 16'h0000, 1'b0);
    endtask
    task automatic t_plateau();
        ppvr_host_i.wr(4'h7, 16'hFFD6);
        rchk(4'h7, 16'h0015, 1'b1);
        chk({12'h0, psel}, 16'h0005);
    endtask
    task automatic t_verify();
        for (int s = 0; s < 4; s++) begin
            ppvr_host_i.wr(4'h8, {12'hFFF, s[1:0], 2'b11});
            rchk(4'h8, {12'h0, s[1:0], 1'b0, ~^s[1:0]}, 1'b1);
            verify_start(s == 2, s == 3);
        end
    endtask
    task automatic t_first();
        @(posedge clk);
        efm <= 1'b1;
        @(posedge clk);
        efm <= 1'b0;
        rchk(4'h8, 16'h0001, 1'b1);
        verify_start(1'b0, 1'b0);
        // first-mode entry in the same cycle as a selector write still clears it
        fork
            ppvr_host_i.wr(4'h8, 16'h0008);
            begin
                @(posedge clk);
                efm <= 1'b1;
                @(posedge clk);
                efm <= 1'b0;
            end
        join
        rchk(4'h8, 16'h0001, 1'b1);
        verify_start(1'b0, 1'b0);
    endtask
    // reset in mid-run restores both reset words and clears the flag
    task automatic t_midreset();
        ppvr_host_i.wr(4'h8, 16'h000C);
        ppvr_host_i.msg(1'b1);
        @(posedge clk);
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        rchk(4'h7, 16'h003D, 1'b1);
        rchk(4'h8, 16'h0001, 1'b1);
        chk({12'h0, psel}, 16'h000F);
    endtask
    task automatic t_flag();
        ppvr_host_i.msg(1'b1);
        rchk(4'h7, 16'h0016, 1'b1);
        ppvr_host_i.msg(1'b0);
        rchk(4'h7, 16'h0015, 1'b1);
    endtask
    task automatic give_verdict();
        if (fails == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // reset, then the scenarios in order
    initial begin
        {resetn, efm, evm} = 3'b0;
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        t_reset();
        t_plateau();
        t_verify();
        t_first();
        t_flag();
        t_midreset();
        give_verdict();
    end
    // watchdog against a hang
    initial begin
        repeat (2000) @(posedge clk);
        fails++;
        give_verdict();
    end
endmodule
